// ---- src/lirc_ctrl.sv ----
// Instruction decode, busy gating, reset sequence and serial framing
//
// Function
// - Reset performs full clear over RAM_DEPTH (128) cycles
// - Reset: increment, no shift, display off
// - Reset: 8-bit, one line, normal set, 1:18
// - Busy held high through 2 ms initialisation
// - Reset clears icon, config, temp, voltage levels
// - Reset ends returning serial framer to idle
// - Only instruction and data holding registers
// - Busy high throughout each instruction execution
// - Status read served while idle or executing, not during init
// - Instructions arriving while busy are discarded
// - Data access steps pointer by one
// - Follow shift accompanies each data write
// - Serial: control byte then command byte
// - Serial direction comes from address bit
// - Function set loads width, lines, mux, set
// - Status read returns busy and pointer
// - Data read returns RAM byte, 3 cycles
// - Data write stores RAM byte, 3 cycles
// - Clear blanks display, pointer zero, 165 cycles
// - Entry mode sets step and shift
// - Display off enters power-down
`default_nettype none
module lirc_ctrl #(
	parameter int INIT_CYCLES = lirc_pkg::INIT_CYCLES,
	parameter int RAM_DEPTH = 128
) (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic NRST,
	input wire logic CE,
	// Parallel host port
	input wire logic PAR_STB,
	input wire logic PAR_RS,
	input wire logic PAR_READ,
	input wire logic [7:0] PAR_DIN,
	// Serial byte port, after address phase
	input wire logic SER_START,
	input wire logic SER_READ,
	input wire logic SER_STB,
	input wire logic [7:0] SER_DIN,
	input wire logic SER_RD_STB,
	// Answers
	output logic [7:0] DOUT,
	output logic DOUT_VALID,
	output logic BUSY,
	output logic [6:0] RAM_POINTER,
	output logic DISPLAY_SHIFT,
	output logic POWER_DOWN,
	output lirc_pkg::lirc_cfg_t CFG,
	output logic SER_IDLE
);
	////////////////////////////////////////////////////////////////
	logic [7:0] ram [RAM_DEPTH];
	lirc_pkg::lirc_state_t st_r, st_nxt;
	lirc_pkg::lirc_ser_t ser_r, ser_nxt;
	lirc_pkg::lirc_cfg_t cfg_r, cfg_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	logic [7:0] instr_holding_reg_r, instr_holding_reg_nxt;
	logic [7:0] data_holding_reg_r, data_holding_reg_nxt;
	logic [6:0] ptr_r, ptr_nxt;
	logic [7:0] dout_r, dout_nxt;
	logic dval_r, dval_nxt, shift_r, shift_nxt, ser_rs_r, ser_rs_nxt;
	logic clr_r, clr_nxt, clr_run_r, clr_run_nxt;
	logic [6:0] clr_idx_r, clr_idx_nxt;
	logic wr_ram, req, req_rs, req_rd;
	logic [7:0] req_d;
	logic [6:0] ptr_step;

	////////////////////////////////////////////////////////////////
	// Request merge; serial direction from address bit
	always_comb
	begin
		req = 1'b0;
		req_rs = PAR_RS;
		req_rd = PAR_READ;
		req_d = PAR_DIN;
		ser_nxt = ser_r;
		ser_rs_nxt = ser_rs_r;
		if (SER_START)
			ser_nxt = lirc_pkg::SR_CTRL;
		else if (SER_READ && SER_RD_STB)
		begin
			req = 1'b1;
			req_rs = ser_rs_r;
			req_rd = 1'b1;
		end
		else if (SER_STB)
		begin
			case (ser_r)
				lirc_pkg::SR_CTRL:
				begin
					ser_rs_nxt = SER_DIN[lirc_pkg::CTRL_RS_BIT];
					ser_nxt = SER_DIN[lirc_pkg::CTRL_MORE_BIT] ? lirc_pkg::SR_CMD
						: lirc_pkg::SR_DATA;
				end
				lirc_pkg::SR_CMD:
				begin
					req = 1'b1;
					req_rs = ser_rs_r;
					req_rd = 1'b0;
					req_d = SER_DIN;
					ser_nxt = lirc_pkg::SR_CTRL;
				end
				lirc_pkg::SR_DATA:
				begin
					req = 1'b1;
					req_rs = ser_rs_r;
					req_rd = 1'b0;
					req_d = SER_DIN;
				end
				default: ser_nxt = lirc_pkg::SR_CTRL;
			endcase
		end
		else if (PAR_STB)
			req = 1'b1;
	end

	////////////////////////////////////////////////////////////////
	assign ptr_step = cfg_r.address_step_dir ? 7'(ptr_r + 7'h01) : 7'(ptr_r - 7'h01);

	always_comb
	begin
		st_nxt = st_r;
		cfg_nxt = cfg_r;
		cnt_nxt = cnt_r;
		ptr_nxt = ptr_r;
		instr_holding_reg_nxt = instr_holding_reg_r;
		data_holding_reg_nxt = data_holding_reg_r;
		dout_nxt = dout_r;
		dval_nxt = 1'b0;
		shift_nxt = 1'b0;
		wr_ram = 1'b0;
		clr_nxt = 1'b0;
		case (st_r)
			lirc_pkg::ST_INIT:
			begin
				if (cnt_r >= 32'(INIT_CYCLES - 1) && !clr_r && !clr_run_r)
				begin
					st_nxt = lirc_pkg::ST_IDLE;
					cnt_nxt = '0;
				end
				else
					cnt_nxt = cnt_r + 32'h1;
			end
			lirc_pkg::ST_IDLE, lirc_pkg::ST_EXEC:
			begin
				if (st_r == lirc_pkg::ST_EXEC)
				begin
					if (cnt_r <= 32'h1)
						st_nxt = lirc_pkg::ST_IDLE;
					cnt_nxt = cnt_r - 32'h1;
				end
				if (req && !req_rs && req_rd)
				begin
					dout_nxt = {BUSY, ptr_r};
					dval_nxt = 1'b1;
				end
				else if (req && st_r == lirc_pkg::ST_IDLE)
				begin
					st_nxt = lirc_pkg::ST_EXEC;
					cnt_nxt = 32'(lirc_pkg::INSTR_CYCLES);
					if (req_rs && req_rd)
					begin
						dout_nxt = ram[ptr_r];
						dval_nxt = 1'b1;
						ptr_nxt = ptr_step;
					end
					else if (req_rs)
					begin
						data_holding_reg_nxt = req_d;
						wr_ram = 1'b1;
						ptr_nxt = ptr_step;
						shift_nxt = cfg_r.display_follow_shift;
					end
					else
					begin
						instr_holding_reg_nxt = req_d;
						if (req_d == lirc_pkg::OP_CLEAR)
						begin
							clr_nxt = 1'b1;
							ptr_nxt = lirc_pkg::PTR_RESET;
							cnt_nxt = 32'(lirc_pkg::CLEAR_CYCLES);
						end
						else if (!cfg_r.extended_set_sel)
						begin
							if (req_d[7:1] == lirc_pkg::OP_HOME[7:1])
								ptr_nxt = lirc_pkg::PTR_RESET;
							else if (req_d[7:2] == lirc_pkg::OP_ENTRY_PFX[5:0])
							begin
								cfg_nxt.address_step_dir = req_d[1];
								cfg_nxt.display_follow_shift = req_d[0];
							end
							else if (req_d[7:3] == lirc_pkg::OP_DISP_PFX)
							begin
								cfg_nxt.display_on = req_d[2];
								cfg_nxt.cursor_on = req_d[1];
								cfg_nxt.cursor_blink = req_d[0];
							end
							else if (req_d[7] == 1'b1)
								ptr_nxt = req_d[6:0];
						end
						else
						begin
							if (req_d[7:1] == lirc_pkg::OP_SCFG_PFX)
								cfg_nxt.screen_cfg = req_d[0];
							else if (req_d[7:2] == lirc_pkg::OP_DCFG_PFX)
								cfg_nxt.display_cfg = req_d[1:0];
							else if (req_d[7:3] == lirc_pkg::OP_ICON_PFX)
							begin
								cfg_nxt.icon_enable = req_d[2];
								cfg_nxt.icon_blink = req_d[1];
							end
							else if (req_d[7:2] == lirc_pkg::OP_TEMP_PFX)
							begin
								cfg_nxt.temp_coeff_low = req_d[1];
								cfg_nxt.temp_coeff_high = req_d[0];
							end
							else if (req_d[7] == lirc_pkg::OP_VLCD_PFX)
							begin
								if (req_d[6])
									cfg_nxt.vlcd_b = {1'b0, req_d[5:0]};
								else
									cfg_nxt.vlcd_a = {1'b0, req_d[5:0]};
							end
						end
						if (req_d[7:5] == lirc_pkg::OP_FUNC_PFX && !req_d[3])
						begin
							cfg_nxt.interface_width_sel = req_d[4];
							cfg_nxt.line_count_sel = req_d[2];
							cfg_nxt.mux_ratio_sel = req_d[1];
							cfg_nxt.extended_set_sel = req_d[0];
						end
					end
				end
			end
			default: st_nxt = lirc_pkg::ST_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// Clear sweep over the text RAM
	always_comb
	begin
		clr_run_nxt = clr_run_r;
		clr_idx_nxt = clr_idx_r;
		if (clr_r)
		begin
			clr_run_nxt = 1'b1;
			clr_idx_nxt = '0;
		end
		else if (clr_run_r)
		begin
			clr_idx_nxt = 7'(clr_idx_r + 7'h01);
			clr_run_nxt = (clr_idx_r != 7'(RAM_DEPTH - 1));
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (!NRST)
		begin
			st_r <= lirc_pkg::ST_INIT;
			ser_r <= lirc_pkg::SR_CTRL;
			ser_rs_r <= 1'b0;
			cfg_r <= lirc_pkg::CFG_RESET;
			cnt_r <= '0;
			ptr_r <= lirc_pkg::PTR_RESET;
			instr_holding_reg_r <= 8'h00;
			data_holding_reg_r <= 8'h00;
			dout_r <= 8'h00;
			dval_r <= 1'b0;
			shift_r <= 1'b0;
			clr_r <= 1'b1;
			clr_run_r <= 1'b0;
			clr_idx_r <= '0;
		end
		else if (CE)
		begin
			st_r <= st_nxt;
			ser_r <= ser_nxt;
			ser_rs_r <= ser_rs_nxt;
			cfg_r <= cfg_nxt;
			cnt_r <= cnt_nxt;
			ptr_r <= ptr_nxt;
			instr_holding_reg_r <= instr_holding_reg_nxt;
			data_holding_reg_r <= data_holding_reg_nxt;
			dout_r <= dout_nxt;
			dval_r <= dval_nxt;
			shift_r <= shift_nxt;
			clr_r <= clr_nxt;
			clr_run_r <= clr_run_nxt;
			clr_idx_r <= clr_idx_nxt;
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (CE && clr_run_r)
			ram[clr_idx_r] <= 8'h20;
		else if (CE && wr_ram)
			ram[ptr_r] <= req_d;
	end

	assign BUSY = (st_r != lirc_pkg::ST_IDLE);
	assign RAM_POINTER = ptr_r;
	assign DOUT = dout_r;
	assign DOUT_VALID = dval_r;
	assign DISPLAY_SHIFT = shift_r;
	assign POWER_DOWN = !cfg_r.display_on;
	assign CFG = cfg_r;
	assign SER_IDLE = (ser_r == lirc_pkg::SR_CTRL);

	////////////////////////////////////////////////////////////////
	busy_exec_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		CE && req && !BUSY && !(!req_rs && req_rd) |=> BUSY)
		else $error("busy not raised on instruction");
	busy_drop_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		CE && req && !BUSY && req_rs && !req_rd ##1 CE [*3] |=> !BUSY)
		else $error("data write not three cycles");
	discard_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		CE && BUSY && req && req_rs && !req_rd |=> $stable(data_holding_reg_r))
		else $error("instruction taken while busy");
	status_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		CE && req && !req_rs && req_rd |=> DOUT == {$past(BUSY), $past(ptr_r)})
		else $error("status read wrong");
	step_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		CE && req && !BUSY && req_rs && !req_rd && cfg_r.address_step_dir
		|=> ptr_r == 7'($past(ptr_r) + 7'h01))
		else $error("pointer not stepped");
	follow_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		CE && req && !BUSY && req_rs && !req_rd |=> DISPLAY_SHIFT == $past(cfg_r.display_follow_shift))
		else $error("follow shift missing");
	clear_ptr_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		CE && req && !BUSY && !req_rs && !req_rd && req_d == lirc_pkg::OP_CLEAR
		|=> ptr_r == lirc_pkg::PTR_RESET && BUSY)
		else $error("clear did not zero pointer");
	power_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		CE && req && !BUSY && !req_rs && !req_rd && !cfg_r.extended_set_sel
		&& req_d[7:3] == lirc_pkg::OP_DISP_PFX && !req_d[2] |=> POWER_DOWN)
		else $error("display off not power down");
	reset_cfg_a: assert property (@(posedge CLK_SYS) $rose(NRST) |-> CFG == lirc_pkg::CFG_RESET
		&& BUSY && SER_IDLE)
		else $error("reset state wrong");
	cov_write_c: cover property (@(posedge CLK_SYS) CE && req && !BUSY && req_rs && !req_rd);
	cov_read_c: cover property (@(posedge CLK_SYS) CE && req && !BUSY && req_rs && req_rd);
	cov_drop_c: cover property (@(posedge CLK_SYS) CE && req && BUSY && req_rs);
	cov_ser_c: cover property (@(posedge CLK_SYS) CE && SER_STB && ser_r == lirc_pkg::SR_CMD);
endmodule
`default_nettype wire

// ---- src/lirc_pkg.sv ----
// Constants, types and instruction codes of the instruction and reset controller
`default_nettype none
package lirc_pkg;
	localparam int CLK_MHZ = 200;
	localparam int CLEAR_CYCLES = 165;
	localparam int INSTR_CYCLES = 3;
	localparam int INIT_TIME_US = 2000;
	localparam int INIT_CYCLES = INIT_TIME_US * CLK_MHZ;
	localparam int PTR_W = 7;
	localparam logic [PTR_W-1:0] PTR_RESET = 7'h00;
	localparam int CTRL_MORE_BIT = 7;
	localparam int CTRL_RS_BIT = 6;
	localparam logic [5:0] CTRL_ZERO = 6'h00;
	localparam logic [7:0] OP_CLEAR = 8'h01;
	localparam logic [7:0] OP_HOME = 8'h02;
	localparam logic [6:0] OP_ENTRY_PFX = 7'h01;
	localparam logic [4:0] OP_DISP_PFX = 5'h01;
	localparam logic [2:0] OP_FUNC_PFX = 3'h1;
	localparam logic [5:0] OP_TEMP_PFX = 6'h04;
	localparam logic [4:0] OP_ICON_PFX = 5'h01;
	localparam logic [5:0] OP_DCFG_PFX = 6'h01;
	localparam logic [6:0] OP_SCFG_PFX = 7'h01;
	localparam logic [0:0] OP_VLCD_PFX = 1'h1;
	localparam logic [6:0] VLCD_OFF = 7'h00;

	typedef enum logic [1:0]
	{
		ST_INIT = 2'b00,
		ST_IDLE = 2'b01,
		ST_EXEC = 2'b10
	} lirc_state_t;

	typedef enum logic [1:0]
	{
		SR_CTRL = 2'b00,
		SR_CMD = 2'b01,
		SR_DATA = 2'b10
	} lirc_ser_t;

	typedef struct packed
	{
		logic address_step_dir;
		logic display_follow_shift;
		logic display_on;
		logic cursor_on;
		logic cursor_blink;
		logic interface_width_sel;
		logic line_count_sel;
		logic mux_ratio_sel;
		logic extended_set_sel;
		logic icon_enable;
		logic icon_blink;
		logic screen_cfg;
		logic [1:0] display_cfg;
		logic temp_coeff_low;
		logic temp_coeff_high;
		logic [6:0] vlcd_a;
		logic [6:0] vlcd_b;
	} lirc_cfg_t;

	localparam lirc_cfg_t CFG_RESET = '{address_step_dir: 1'b1, interface_width_sel: 1'b1,
		vlcd_a: VLCD_OFF, vlcd_b: VLCD_OFF, default: '0};
endpackage
`default_nettype wire

// ---- tb/lirc_host.sv ----
// Host model driving the parallel and serial request ports
`default_nettype none
module lirc_host (
	// Clock and status
	input wire logic CLK_SYS,
	input wire logic BUSY,
	// Parallel requests
	output logic PAR_STB,
	output logic PAR_RS,
	output logic PAR_READ,
	output logic [7:0] PAR_DIN,
	// Serial requests
	output logic SER_START,
	output logic SER_READ,
	output logic SER_STB,
	output logic [7:0] SER_DIN,
	output logic SER_RD_STB
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		{PAR_STB, PAR_RS, PAR_READ, SER_START, SER_READ, SER_STB, SER_RD_STB} = 7'h00;
		PAR_DIN = 8'hA5;
		SER_DIN = 8'h5A;
	end
	// One parallel transfer; data inverted once released
	task automatic par(input logic rs, input logic rd, input logic [7:0] d);
		@(negedge CLK_SYS);
		PAR_RS = rs;
		PAR_READ = rd;
		PAR_DIN = d;
		PAR_STB = 1'b1;
		@(negedge CLK_SYS);
		PAR_STB = 1'b0;
		PAR_DIN = ~d;
	endtask
	task automatic ser_byte(input logic [7:0] d);
		@(negedge CLK_SYS);
		SER_DIN = d;
		SER_STB = 1'b1;
		@(negedge CLK_SYS);
		SER_STB = 1'b0;
		SER_DIN = ~d;
	endtask
	// Start in write direction, then one control byte
	task automatic ser_ctrl(input logic rs);
		@(negedge CLK_SYS);
		SER_START = 1'b1;
		SER_READ = 1'b0;
		@(negedge CLK_SYS);
		SER_START = 1'b0;
		ser_byte({1'b0, rs, 6'h00});
	endtask
	// Control byte with more bit clear, then one byte in the data phase
	task automatic ser_cmd(input logic rs, input logic [7:0] d);
		ser_ctrl(rs);
		ser_byte(d);
	endtask
	// Restart in read direction, then one read byte
	task automatic ser_read;
		@(negedge CLK_SYS);
		SER_START = 1'b1;
		SER_READ = 1'b1;
		@(negedge CLK_SYS);
		SER_START = 1'b0;
		@(negedge CLK_SYS);
		SER_RD_STB = 1'b1;
		@(negedge CLK_SYS);
		SER_RD_STB = 1'b0;
		SER_READ = 1'b0;
	endtask
	// Bounded wait for busy low before a new instruction
	task automatic wait_idle(output bit ok);
		ok = 1'b0;
		for (int i = 0; i < 500 && !ok; i++)
		begin
			@(negedge CLK_SYS);
			ok = (BUSY === 1'b0);
		end
	endtask
endmodule
`default_nettype wire

// ---- tb/lirc_instruction_reset_control_tb.sv ----
// Self-checking bench of the instruction and reset controller
`default_nettype none
module lirc_instruction_reset_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// Init outlasts the reset clear sweep
	localparam int INIT_N = 200;
	logic CLK_SYS = 1'b0;
	logic NRST = 1'b0;
	logic CE = 1'b1;
	logic PAR_STB, PAR_RS, PAR_READ, SER_START, SER_READ, SER_STB, SER_RD_STB;
	logic [7:0] PAR_DIN, SER_DIN, DOUT;
	logic DOUT_VALID, BUSY, DISPLAY_SHIFT, POWER_DOWN, SER_IDLE;
	logic [6:0] RAM_POINTER, p0;
	lirc_pkg::lirc_cfg_t CFG;
	int error_cnt = 0;
	int cmp_count = 0;
	int n;
	bit seen;
	always #2.5 CLK_SYS = ~CLK_SYS;
	lirc_ctrl #(.INIT_CYCLES(INIT_N)) i_lirc_ctrl (.CLK_SYS(CLK_SYS), .NRST(NRST), .CE(CE),
		.PAR_STB(PAR_STB), .PAR_RS(PAR_RS), .PAR_READ(PAR_READ), .PAR_DIN(PAR_DIN),
		.SER_START(SER_START), .SER_READ(SER_READ), .SER_STB(SER_STB), .SER_DIN(SER_DIN),
		.SER_RD_STB(SER_RD_STB), .DOUT(DOUT), .DOUT_VALID(DOUT_VALID), .BUSY(BUSY),
		.RAM_POINTER(RAM_POINTER), .DISPLAY_SHIFT(DISPLAY_SHIFT), .POWER_DOWN(POWER_DOWN),
		.CFG(CFG), .SER_IDLE(SER_IDLE));
	lirc_host i_lirc_host (.CLK_SYS(CLK_SYS), .BUSY(BUSY), .PAR_STB(PAR_STB), .PAR_RS(PAR_RS),
		.PAR_READ(PAR_READ), .PAR_DIN(PAR_DIN), .SER_START(SER_START), .SER_READ(SER_READ),
		.SER_STB(SER_STB), .SER_DIN(SER_DIN), .SER_RD_STB(SER_RD_STB));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %s expected %0h seen %0h", name, exp, got);
		end
	endtask
	task automatic final_report;
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic idle;
		bit ok;
		i_lirc_host.wait_idle(ok);
		if (!ok)
		begin
			error_cnt++;
			$display("ERROR busy wait timed out");
			final_report();
		end
	endtask
	// Busy length counted from the cycle after the taking edge
	task automatic busy_len(input string name, input int exp);
		n = 0;
		while (BUSY === 1'b1 && n < 400)
		begin
			n++;
			@(negedge CLK_SYS);
		end
		chk(name, exp, n);
	endtask
	task automatic cmd(input logic [7:0] d, input int cyc);
		i_lirc_host.par(1'b0, 1'b0, d);
		busy_len("busy cycles", cyc);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk("serial idle", 1, SER_IDLE);
		chk("pointer", 0, RAM_POINTER);
		n = 0;
		while (BUSY === 1'b1 && n < 400)
		begin
			n++;
			@(negedge CLK_SYS);
		end
		chk("init busy", 1, n >= INIT_N - 1 && n <= INIT_N + 1);
		chk("cfg", 32'(lirc_pkg::CFG_RESET), 32'(CFG));
		chk("power down", 1, POWER_DOWN);
		$display("reset test done");
	endtask
	task automatic t_write_read;
		i_lirc_host.par(1'b1, 1'b0, 8'h41);
		busy_len("write busy", 3);
		chk("pointer up", 1, RAM_POINTER);
		cmd(8'h04, 3);
		i_lirc_host.par(1'b1, 1'b0, 8'h55);
		idle();
		chk("pointer down", 0, RAM_POINTER);
		i_lirc_host.par(1'b1, 1'b1, 8'h00);
		chk("read valid", 1, DOUT_VALID);
		chk("read data", 8'h41, DOUT);
		busy_len("read busy", 3);
		cmd(8'h06, 3);
		$display("write read test done");
	endtask
	task automatic t_busy_drop;
		p0 = RAM_POINTER;
		i_lirc_host.par(1'b1, 1'b0, 8'h33);
		i_lirc_host.par(1'b1, 1'b0, 8'h44);
		idle();
		chk("dropped write", 7'(p0 + 7'h01), RAM_POINTER);
		i_lirc_host.par(1'b0, 1'b0, lirc_pkg::OP_CLEAR);
		i_lirc_host.par(1'b0, 1'b1, 8'h00);
		chk("status valid", 1, DOUT_VALID);
		chk("status", {1'b1, lirc_pkg::PTR_RESET}, DOUT);
		idle();
		$display("busy drop test done");
	endtask
	// Clock enable low freezes the busy count
	task automatic t_freeze;
		p0 = RAM_POINTER;
		i_lirc_host.par(1'b1, 1'b0, 8'h5C);
		CE = 1'b0;
		repeat (4) @(negedge CLK_SYS);
		chk("frozen busy", 1, BUSY);
		CE = 1'b1;
		busy_len("resumed busy", 3);
		chk("frozen pointer", 7'(p0 + 7'h01), RAM_POINTER);
		$display("freeze test done");
	endtask
	task automatic t_modes;
		cmd(8'h26, 3);
		chk("width", 0, CFG.interface_width_sel);
		chk("lines", 1, CFG.line_count_sel);
		chk("mux", 1, CFG.mux_ratio_sel);
		chk("ext", 0, CFG.extended_set_sel);
		cmd(lirc_pkg::OP_CLEAR, 165);
		chk("clear pointer", 0, RAM_POINTER);
		cmd(8'h0C, 3);
		chk("display on", 0, POWER_DOWN);
		cmd(8'h08, 3);
		chk("display off", 1, POWER_DOWN);
		for (int s = 0; s < 2; s++)
		begin
			cmd({6'h01, 1'b1, 1'(s)}, 3);
			i_lirc_host.par(1'b1, 1'b0, 8'h2A);
			seen = 1'b0;
			repeat (5)
			begin
				seen |= (DISPLAY_SHIFT === 1'b1);
				@(negedge CLK_SYS);
			end
			chk("follow shift", s, seen);
		end
		$display("mode test done");
	endtask
	task automatic t_serial;
		p0 = RAM_POINTER;
		i_lirc_host.ser_cmd(1'b1, 8'h61);
		chk("serial phase", 0, SER_IDLE);
		idle();
		chk("serial write", 7'(p0 + 7'h01), RAM_POINTER);
		i_lirc_host.ser_cmd(1'b0, 8'h0C);
		idle();
		chk("serial cmd", 0, POWER_DOWN);
		i_lirc_host.ser_read();
		chk("serial status valid", 1, DOUT_VALID);
		chk("serial status", {1'b0, 7'(p0 + 7'h01)}, DOUT);
		i_lirc_host.ser_cmd(1'b0, {1'b1, p0});
		idle();
		i_lirc_host.ser_ctrl(1'b1);
		i_lirc_host.ser_read();
		chk("serial read valid", 1, DOUT_VALID);
		chk("serial read", 8'h61, DOUT);
		busy_len("serial read busy", 3);
		$display("serial test done");
	endtask
	// Reset in mid-run with the framer out of its idle phase
	task automatic t_rerun;
		i_lirc_host.ser_ctrl(1'b0);
		chk("framer out of idle", 0, SER_IDLE);
		NRST = 1'b0;
		repeat (3) @(negedge CLK_SYS);
		NRST = 1'b1;
		t_reset();
		$display("mid-run reset test done");
	endtask
	initial
	begin
		repeat (3) @(negedge CLK_SYS);
		NRST = 1'b1;
		t_reset();
		t_write_read();
		t_busy_drop();
		t_freeze();
		t_modes();
		t_serial();
		t_rerun();
		final_report();
	end
endmodule
`default_nettype wire
